// >>> aphc_regs.svh
// Constants for the parallel converter host controller
`ifndef APHC_REGS_SVH
`define APHC_REGS_SVH
// Notes on behaviour
// - Read after busy falls, or old data.
// - Never read across busy falling edge.
// - Read command: bit15 high, address, don't-care.
// - Register mode stops results; write 0x00 exits.
// - Write frame: bit15 low, address, data.
// - Read a register before writing a series.
// Host command port offsets
`define APHC_ADDR_CTRL 4'h0
`define APHC_ADDR_STAT 4'h1
`define APHC_ADDR_REGCMD 4'h2
`define APHC_ADDR_REGRES 4'h3
`define APHC_ADDR_CRC 4'h4
`define APHC_ADDR_RES0 4'h8
// Control bits
`define APHC_CTRL_START 0
`define APHC_CTRL_STATUS 1
`define APHC_CTRL_CRC 2
`define APHC_CTRL_SWMODE 3
// Register command word: bit 15 selects read, as on the bus; kept clear of the address
`define APHC_CMD_READ 15
// Device register facts
`define APHC_DEV_EXIT_ADDR 7'h00
`define APHC_DEV_CRC_ADDR 7'h21
`define APHC_DEV_CRC_BIT 2
`define APHC_DEV_CFG_ADDR 7'h02
`define APHC_DEV_STATUS_BIT 6
// Strobe timing: low and high phase lengths in ns
`define APHC_STROBE_NS 30
`define APHC_CLK_NS 10
`define APHC_STROBE_CYC ((`APHC_STROBE_NS + `APHC_CLK_NS - 1) / `APHC_CLK_NS)
`define APHC_NCH 8
`endif

// >>> aphc_pkg.sv
// Types of the parallel converter host controller
package aphc_pkg;
  typedef enum logic [5:0] {
    APHC_IDLE = 6'h01,
    APHC_WAIT = 6'h02,
    APHC_RLOW = 6'h04,
    APHC_RHIGH = 6'h08,
    APHC_WLOW = 6'h10,
    APHC_WHIGH = 6'h20
  } aphc_state_e;
  typedef struct packed {
    logic [15:0] dataOut;
    logic dataOe;
    logic chipSelN;
    logic readN;
    logic writeN;
    logic interfaceSelect;
    logic [2:0] osPins;
  } aphc_pins_s;
endpackage : aphc_pkg

// >>> aphc_host.sv
// Host controller driving a converter's parallel port
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "aphc_regs.svh"
module aphc_host #(
  parameter int NCH = `APHC_NCH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] cmdAddr,
  input wire logic [15:0] cmdWdata,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [15:0] cmdRdata,
  output aphc_pkg::aphc_pins_s pins,
  input wire logic [15:0] dataIn,
  input wire logic busy,
  input wire logic firstChannelFlag
);
  import aphc_pkg::*;

  typedef struct packed {
    aphc_state_e st;
    logic [15:0] rdata;
    aphc_pins_s pins;
    logic [3:0] ctrl;
    logic regMode;
    logic pendRead;
    logic [14:0] regCmd;
    logic [15:0] regRes;
    logic [4:0] word;
    logic [3:0] cnt;
    logic [15:0] crc;
    logic [15:0] crcRx;
    logic done;
    logic seqErr;
    logic busyQ;
    logic [NCH-1:0][15:0] res;
    logic [NCH-1:0][7:0] hdr;
  } aphc_state_s;

  aphc_state_s cur_r;
  aphc_state_s cur_nxt;

  // CRC-16 step, polynomial 0x8005 as a plain default
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ 16'h8005) : (r << 1);
    end
    return r;
  endfunction : crcStep

  // Frames in one read burst
  function automatic logic [4:0] burstLen(input logic st, input logic cr);
    logic [4:0] n;
    n = st ? 5'(2 * NCH) : 5'(NCH);
    return cr ? n + 5'h01 : n;
  endfunction : burstLen

  // Next state: pin sequencing and the command port
  always_comb
  begin
    aphc_state_s n;
    logic [4:0] last;
    logic [2:0] chIx;
    n = cur_r;
    last = burstLen(cur_r.ctrl[`APHC_CTRL_STATUS], cur_r.ctrl[`APHC_CTRL_CRC]);
    chIx = cur_r.ctrl[`APHC_CTRL_STATUS] ? cur_r.word[3:1] : cur_r.word[2:0];
    n.busyQ = busy;
    n.pins.interfaceSelect = 1'b0;
    n.pins.osPins = {3{cur_r.ctrl[`APHC_CTRL_SWMODE]}};
    n.rdata = 16'h0000;
    if (cmdRd)
    begin
      unique case (cmdAddr)
        `APHC_ADDR_CTRL: n.rdata = {12'h000, cur_r.ctrl};
        `APHC_ADDR_STAT: n.rdata = {12'h000, cur_r.seqErr, cur_r.regMode, cur_r.done,
                                     cur_r.st != APHC_IDLE};
        `APHC_ADDR_REGRES: n.rdata = cur_r.regRes;
        `APHC_ADDR_CRC: n.rdata = cur_r.crcRx;
        default: if (cmdAddr[3]) n.rdata = cur_r.res[cmdAddr[2:0]];
      endcase
    end
    if (cmdWr && cmdAddr == `APHC_ADDR_CTRL)
    begin
      n.ctrl = cmdWdata[3:0] & 4'he;
    end
    unique case (cur_r.st)
      APHC_IDLE:
      begin
        n.pins.chipSelN = 1'b1;
        n.pins.dataOe = 1'b1;
        n.cnt = 4'h0;
        if (cmdWr && cmdAddr == `APHC_ADDR_REGCMD && cur_r.ctrl[`APHC_CTRL_SWMODE])
        begin
          n.regCmd = cmdWdata[14:0];
          n.pendRead = cmdWdata[`APHC_CMD_READ];
          n.pins.dataOut = {cmdWdata[`APHC_CMD_READ], cmdWdata[14:8],
                            cmdWdata[`APHC_CMD_READ] ? 8'h00 : cmdWdata[7:0]};
          n.pins.chipSelN = 1'b0;
          n.pins.writeN = 1'b0;
          n.pins.dataOe = 1'b0;
          n.st = APHC_WLOW;
        end
        else if (cmdWr && cmdAddr == `APHC_ADDR_CTRL && cmdWdata[`APHC_CTRL_START])
        begin
          n.done = 1'b0;
          n.seqErr = cur_r.regMode;
          n.word = 5'h00;
          n.crc = 16'hffff;
          n.st = cur_r.regMode ? APHC_IDLE : APHC_WAIT;
        end
      end
      APHC_WAIT:
      begin
        // start only once busy is low, so no read spans its fall
        if (!busy && !cur_r.busyQ)
        begin
          n.pins.chipSelN = 1'b0;
          n.pins.readN = 1'b0;
          n.st = APHC_RLOW;
        end
      end
      APHC_RLOW:
      begin
        n.cnt = cur_r.cnt + 4'h1;
        if (cur_r.cnt == 4'(`APHC_STROBE_CYC - 1))
        begin
          n.cnt = 4'h0;
          n.pins.readN = 1'b1;
          n.word = cur_r.word + 5'h01;
          if (cur_r.pendRead)
          begin
            n.regRes = {1'b0, dataIn[14:0]};
            n.pendRead = 1'b0;
          end
          else
          begin
            n.crc = crcStep(cur_r.crc, dataIn);
            if (cur_r.word == last - 5'h01 && cur_r.ctrl[`APHC_CTRL_CRC])
              n.crcRx = dataIn;
            else if (cur_r.ctrl[`APHC_CTRL_STATUS] && cur_r.word[0])
              n.hdr[chIx] = dataIn[15:8];
            else
              n.res[chIx] = dataIn;
            if (cur_r.word == 5'h00 && !firstChannelFlag)
              n.seqErr = 1'b1;
          end
          n.st = APHC_RHIGH;
        end
      end
      APHC_RHIGH:
      begin
        n.cnt = cur_r.cnt + 4'h1;
        if (cur_r.cnt == 4'(`APHC_STROBE_CYC - 1))
        begin
          n.cnt = 4'h0;
          if (cur_r.word == last || cur_r.regMode)
          begin
            n.pins.chipSelN = 1'b1;
            n.done = 1'b1;
            n.st = APHC_IDLE;
          end
          else
          begin
            n.pins.readN = 1'b0;
            n.st = APHC_RLOW;
          end
        end
      end
      APHC_WLOW:
      begin
        n.cnt = cur_r.cnt + 4'h1;
        n.pins.writeN = 1'b0;
        if (cur_r.cnt == 4'(`APHC_STROBE_CYC - 1))
        begin
          n.cnt = 4'h0;
          n.pins.writeN = 1'b1;
          n.st = APHC_WHIGH;
        end
      end
      APHC_WHIGH:
      begin
        n.cnt = cur_r.cnt + 4'h1;
        if (cur_r.cnt == 4'(`APHC_STROBE_CYC - 1))
        begin
          n.cnt = 4'h0;
          n.pins.dataOe = 1'b1;
          if (cur_r.pendRead)
          begin
            n.regMode = 1'b1;
            n.word = 5'h00;
            n.pins.readN = 1'b0;
            n.st = APHC_RLOW;
          end
          else
          begin
            if (cur_r.regCmd[14:8] == `APHC_DEV_EXIT_ADDR)
              n.regMode = 1'b0;
            else if (cur_r.regCmd[14:8] == `APHC_DEV_CRC_ADDR)
              n.ctrl[`APHC_CTRL_CRC] = cur_r.regCmd[`APHC_DEV_CRC_BIT];
            else if (cur_r.regCmd[14:8] == `APHC_DEV_CFG_ADDR)
              n.ctrl[`APHC_CTRL_STATUS] = cur_r.regCmd[`APHC_DEV_STATUS_BIT];
            n.pins.chipSelN = 1'b1;
            n.done = 1'b1;
            n.st = APHC_IDLE;
          end
        end
      end
    endcase
    cur_nxt = n;
  end

  // State register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cur_r <= '0;
      cur_r.st <= APHC_IDLE;
      cur_r.pins.chipSelN <= 1'b1;
      cur_r.pins.readN <= 1'b1;
      cur_r.pins.writeN <= 1'b1;
      cur_r.pins.dataOe <= 1'b1;
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  assign pins = cur_r.pins;
  assign cmdRdata = cur_r.rdata;

  // Chip select drops only together with a strobe, in the same cycle
  property p_cs_frames;
    @(posedge clk) disable iff (sys_rst)
      $fell(pins.chipSelN) |-> !pins.readN || !pins.writeN;
  endproperty
  a_cs_frames: assert property (p_cs_frames) else $error("select without strobe");

  // Never start a result read while busy high; register reply reads are not checked
  property p_no_busy_read;
    @(posedge clk) disable iff (sys_rst)
      $fell(pins.readN) && !cur_r.pendRead |-> !$past(busy);
  endproperty
  a_no_busy_read: assert property (p_no_busy_read) else $error("read during busy");

  // Read strobe low for one full phase, then released
  sequence s_rd_phase;
    !pins.readN [*3] ##1 pins.readN;
  endsequence
  property p_rd_phase;
    @(posedge clk) disable iff (sys_rst)
      $fell(pins.readN) |-> s_rd_phase;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read strobe length");

  // Write strobe low for one full phase, so the frame is set up before the rise
  sequence s_wr_phase;
    !pins.writeN [*3] ##1 pins.writeN;
  endsequence
  property p_wr_phase;
    @(posedge clk) disable iff (sys_rst)
      $fell(pins.writeN) |-> s_wr_phase;
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write strobe length");

  // Outside a frame no strobe and no host drive
  property p_strobe_in_frame;
    @(posedge clk) disable iff (sys_rst)
      pins.chipSelN |-> pins.readN && pins.writeN && pins.dataOe;
  endproperty
  a_strobe_in_frame: assert property (p_strobe_in_frame) else $error("strobe outside frame");

  // Host lines released whenever the read strobe is low
  property p_no_contention;
    @(posedge clk) disable iff (sys_rst)
      !pins.readN |-> pins.dataOe;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  // A read command is followed by its reply frame one phase later
  sequence s_read_cmd;
    $rose(pins.writeN) && pins.dataOut[15];
  endsequence
  sequence s_write_cmd;
    $rose(pins.writeN) && !pins.dataOut[15];
  endsequence
  property p_read_reply;
    @(posedge clk) disable iff (sys_rst)
      s_read_cmd |-> ##3 $fell(pins.readN);
  endproperty
  a_read_reply: assert property (p_read_reply) else $error("no reply frame");

  // A write frame ends the select one phase after the latch edge
  property p_write_close;
    @(posedge clk) disable iff (sys_rst)
      s_write_cmd |-> ##3 $rose(pins.chipSelN);
  endproperty
  a_write_close: assert property (p_write_close) else $error("write frame not closed");
endmodule : aphc_host

// >>> aphc_dev_model.sv
// Behavioural converter on the far side of the parallel host port
`timescale 1ns/1ps
module aphc_dev_model
  import aphc_pkg::*;
(
  input wire logic clk,
  input wire aphc_pkg::aphc_pins_s pins,
  output logic [15:0] dataIn,
  output logic busy,
  output logic firstChannelFlag
);
  logic [15:0] res [8];
  logic [15:0] nextRes [8];
  logic [7:0] regs [128];
  logic [15:0] word;
  logic [15:0] crcWord;
  logic [4:0] hdrFlags;
  logic [6:0] regAddr;
  logic [2:0] ch;
  logic regMode;
  logic frst;
  logic swMode;
  logic stsOn;
  logic crcOn;
  logic drive;
  int idx;

  initial
  begin
    for (int i = 0; i < 128; i++)
      regs[i] = 8'h00;
    busy = 1'b0;
    regMode = 1'b0;
    frst = 1'b0;
    word = 16'h0000;
    idx = 0;
  end

  // Mode decode; released lines show the inverse so stale data never passes
  assign swMode = pins.osPins == 3'b111;
  assign stsOn = swMode && regs[7'h02][6];
  assign crcOn = swMode && regs[7'h21][2];
  assign drive = !pins.chipSelN && !pins.interfaceSelect && (!regMode || !pins.readN);
  assign dataIn = drive ? word : ~word;
  assign firstChannelFlag = pins.chipSelN ? ~frst : frst;

  // Conversion: results reload only as busy falls
  task automatic convert(input int cycles);
    busy = 1'b1;
    repeat (cycles) @(posedge clk);
    busy = 1'b0;
    res = nextRes;
    idx = 0;
  endtask : convert

  // Each read fall outside register mode steps the frame sequence
  always @(negedge pins.readN)
    if (!pins.chipSelN && !pins.interfaceSelect)
    begin
      if (regMode)
        word = {1'b0, regAddr, regs[regAddr]};
      else
      begin
        ch = stsOn ? idx[3:1] : idx[2:0];
        if (crcOn && idx == (stsOn ? 16 : 8))
          word = crcWord;
        else if (stsOn && idx[0])
          word = {hdrFlags, ch, 8'h00};
        else
          word = res[ch];
        frst = (idx == 0);
        idx++;
      end
    end

  // Frames latched on write rise, software mode only
  always @(posedge pins.writeN)
    if (!pins.chipSelN && !pins.dataOe && swMode)
    begin
      if (pins.dataOut[15])
      begin
        regMode = 1'b1;
        regAddr = pins.dataOut[14:8];
      end
      else
      begin
        regs[pins.dataOut[14:8]] = pins.dataOut[7:0];
        if (pins.dataOut[14:8] == 7'h00)
          regMode = 1'b0;
      end
    end
endmodule : aphc_dev_model

// >>> aphc_host_tb_top.sv
// Self-checking bench for the parallel converter host controller
`timescale 1ns/1ps
`include "aphc_regs.svh"
`define CHK(nm, e, s) begin checkCount++; if ((s) !== (e)) begin nFail++; $display("BAD %s exp %h got %h", nm, e, s); end end
module aphc_host_tb_top;
  import aphc_pkg::*;
  logic clk;
  logic sys_rst;
  logic cmdWr;
  logic cmdRd;
  logic busy;
  logic firstChannelFlag;
  logic [3:0] cmdAddr;
  logic [15:0] cmdWdata;
  logic [15:0] cmdRdata;
  logic [15:0] dataIn;
  logic [15:0] rd;
  logic [31:0] lfsr;
  logic [15:0] expRes [8];
  aphc_pins_s pins;
  int nFail;
  int checkCount;
  int cyc;

  aphc_host dut_u (.clk(clk), .sys_rst(sys_rst), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .pins(pins), .dataIn(dataIn),
    .busy(busy), .firstChannelFlag(firstChannelFlag));
  aphc_dev_model dev_u (.clk(clk), .pins(pins), .dataIn(dataIn), .busy(busy),
    .firstChannelFlag(firstChannelFlag));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the longest burst sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      nFail++;
      finishTest();
    end
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, output logic [15:0] d);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    #1 d = cmdRdata;
  endtask : rdc

  // Bounded poll until the controller reports no activity
  task automatic idle();
    for (int i = 0; i < 300; i++)
    begin
      rdc(`APHC_ADDR_STAT, rd);
      if (rd[0] === 1'b0)
        break;
    end
    `CHK("idle", 1'b0, rd[0])
  endtask : idle

  // New random conversion; only started while the port is quiet
  task automatic conv();
    for (int i = 0; i < 8; i++)
    begin
      lfsr = nextRand(lfsr);
      expRes[i] = lfsr[15:0];
      dev_u.nextRes[i] = lfsr[15:0];
    end
    dev_u.hdrFlags = lfsr[20:16];
    dev_u.crcWord = lfsr[31:16];
    dev_u.convert(50);
  endtask : conv

  task automatic burst(input logic [15:0] ctrl);
    conv();
    wr(`APHC_ADDR_CTRL, ctrl);
    idle();
    for (int i = 0; i < 8; i++)
    begin
      rdc(4'(`APHC_ADDR_RES0 + i), rd);
      `CHK("result", expRes[i], rd)
    end
  endtask : burst

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finishTest

  // Main sequence: hardware burst, register series, software burst
  initial
  begin
    lfsr = 32'h8d64;
    cmdAddr = 4'h0;
    cmdWdata = 16'h0000;
    cmdWr = 1'b0;
    cmdRd = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(`APHC_ADDR_STAT, rd);
    `CHK("status", 16'h0000, rd)
    `CHK("csIdle", 1'b1, pins.chipSelN)
    burst(16'h0001);
    `CHK("osPins", 3'b000, pins.osPins)
    `CHK("select", 1'b0, pins.interfaceSelect)
    wr(`APHC_ADDR_CTRL, 16'h0008);
    repeat (2) @(posedge clk);
    `CHK("osPins", 3'b111, pins.osPins)
    wr(`APHC_ADDR_REGCMD, 16'ha100);
    idle();
    `CHK("regMode", 1'b1, rd[2])
    wr(`APHC_ADDR_REGCMD, 16'h2104);
    idle();
    wr(`APHC_ADDR_REGCMD, 16'h0240);
    idle();
    wr(`APHC_ADDR_REGCMD, 16'ha100);
    idle();
    rdc(`APHC_ADDR_REGRES, rd);
    `CHK("regData", 8'h04, rd[7:0])
    wr(`APHC_ADDR_CTRL, 16'h0009);
    idle();
    `CHK("seqErr", 1'b1, rd[3])
    wr(`APHC_ADDR_REGCMD, 16'h0000);
    idle();
    `CHK("regMode", 1'b0, rd[2])
    burst(16'h000f);
    rdc(`APHC_ADDR_CRC, rd);
    `CHK("crc", dev_u.crcWord, rd)
    rdc(`APHC_ADDR_STAT, rd);
    `CHK("seqErr", 4'h2, rd[3:0])
    finishTest();
  end
endmodule : aphc_host_tb_top
